// ---- otp_port.sv ----
// OTP array with run-mode fetch port and parallel programming port.
// Assumes programming pins are asynchronous to CLK_I; run fetch is synchronous.
`timescale 1ns/1ps
`default_nettype none
module otp_port
  import otp_pkg::*;
#(
  parameter int unsigned FILL_LANES = 8
)
(
  input  wire logic                  CLK_I,
  input  wire logic                  RSTN_I,
  input  wire logic                  TEST_I,
  input  wire logic                  UPPER_ADDRESS_BIT_I,
  input  wire logic [7:0]            ADDRESS_HIGH_BYTE_I,
  input  wire logic [7:0]            ADDRESS_LOW_BYTE_I,
  input  wire logic [7:0]            DATA_LINES_I,
  output logic      [7:0]            DATA_LINES_O,
  output logic                       DATA_LINES_OE_O,
  input  wire logic                  CHIP_SELECT_N_I,
  input  wire logic                  OUTPUT_ENABLE_N_I,
  input  wire logic                  PROGRAM_STROBE_N_I,
  input  wire logic [RUN_ADDR_W-1:0] FETCH_ADDR_I,
  input  wire logic                  FETCH_REQ_I,
  output logic      [7:0]            FETCH_DATA_O,
  output logic                       FETCH_VALID_O,
  output logic                       PROGRAMMING_MODE_O
);
  // Fill writes a whole row per cycle so the erase walk stays short
  localparam int unsigned LANE_W = $clog2(FILL_LANES);
  localparam int unsigned ROW_W  = 8 * FILL_LANES;
  localparam int unsigned ROWS   = MEM_BYTES / FILL_LANES;
  localparam int unsigned WORD_W = ADDR_W - LANE_W;
  localparam int unsigned SYNC_W = ADDR_W + 12;

  // Idle pin levels: controls high, so no false strobe edge after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b0, 3'b111, {(ADDR_W + 8){1'b0}}};

  if (FILL_LANES < 2 || FILL_LANES > 64 || (FILL_LANES & (FILL_LANES - 1)) != 0)
  begin : g_bad_lanes
    $error("FILL_LANES must be a power of two from 2 to 64");
  end

  // Translation assumes each run window matches its programming window
  if (PRG_PROG_HI - PRG_PROG_LO != RUN_PROG_HI - RUN_PROG_LO)
  begin : g_bad_prog_map
    $error("program windows differ in size");
  end

  if (PRG_FONT_HI - PRG_FONT_LO != RUN_FONT_HI - RUN_FONT_LO)
  begin : g_bad_font_map
    $error("font windows differ in size");
  end

  if (PRG_VEC_HI - PRG_VEC_LO != RUN_VEC_HI - RUN_VEC_LO)
  begin : g_bad_vec_map
    $error("vector windows differ in size");
  end

  if (MEM_BYTES != (1 << ADDR_W))
  begin : g_bad_depth
    $error("array depth must match the address width");
  end

  // Sync stages: pins come from the programmer, unrelated to CLK_I
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end
    else
    begin
      sync1 <= {TEST_I, PROGRAM_STROBE_N_I, OUTPUT_ENABLE_N_I, CHIP_SELECT_N_I,
                UPPER_ADDRESS_BIT_I, ADDRESS_HIGH_BYTE_I, ADDRESS_LOW_BYTE_I,
                DATA_LINES_I};
      sync2 <= sync1;
    end
  end

  wire              s_test   = sync2[ADDR_W+11];
  wire              s_pgm_n  = sync2[ADDR_W+10];
  wire              s_oe_n   = sync2[ADDR_W+9];
  wire              s_cs_n   = sync2[ADDR_W+8];
  wire [ADDR_W-1:0] s_addr   = sync2[ADDR_W+7:8];
  wire [7:0]        s_data   = sync2[7:0];

  // Test pin high means programming, low means run
  wire prog_mode = s_test;
  wire selected  = prog_mode && !s_cs_n;

  // Writable and readable windows; lower font part is readable, not burnable
  wire in_prog   = (s_addr >= PRG_PROG_LO) && (s_addr <= PRG_PROG_HI);
  wire in_font   = (s_addr >= PRG_FONT_LO) && (s_addr <= PRG_FONT_HI);
  wire in_vec    = (s_addr >= PRG_VEC_LO) && (s_addr <= PRG_VEC_HI);
  wire font_wr   = (s_addr >= PRG_FONT_WR) && (s_addr <= PRG_FONT_HI);
  wire writable  = in_prog || font_wr || in_vec;
  wire readable  = in_prog || in_font || in_vec;

  // Array geometry: rows of FILL_LANES bytes
  logic [ROW_W-1:0]  mem [ROWS];
  logic              mem_init;
  logic [WORD_W-1:0] init_idx;

  // Pin-side row and lane select
  wire [WORD_W-1:0] s_word = s_addr[ADDR_W-1:LANE_W];
  wire [LANE_W-1:0] s_lane = s_addr[LANE_W-1:0];
  wire [ROW_W-1:0]  s_row  = mem[s_word];
  wire [7:0]        s_byte = s_row[8 * s_lane +: 8];

  // Strobe tracker: one commit per low pulse; OTP bits only clear
  otp_strobe_t strobe_state;
  otp_strobe_t next_strobe_state;
  wire strobe_armed = (strobe_state == OTP_IDLE);
  wire strobe_fall  = strobe_armed && !s_pgm_n;
  wire do_write     = selected && strobe_fall && writable && s_oe_n && mem_init;

  always_comb
  begin
    next_strobe_state = strobe_state;
    unique case (strobe_state)
      OTP_IDLE:
        if (!s_pgm_n)
          next_strobe_state = OTP_BURN;
      OTP_BURN:
        if (s_pgm_n)
          next_strobe_state = OTP_RELAX;
      OTP_RELAX:
        next_strobe_state = OTP_IDLE;
      default:
        next_strobe_state = OTP_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      strobe_state <= OTP_IDLE;
    else
      strobe_state <= next_strobe_state;
  end

  // Run-mode translation to the shared array
  wire [RUN_ADDR_W-1:0] fa = FETCH_ADDR_I;
  wire run_prog = (fa >= RUN_PROG_LO) && (fa <= RUN_PROG_HI);
  wire run_font = (fa >= RUN_FONT_LO) && (fa <= RUN_FONT_HI);
  wire run_vec  = (fa >= RUN_VEC_LO) && (fa <= RUN_VEC_HI);
  wire [RUN_ADDR_W-1:0] prog_off = fa - RUN_PROG_LO + {3'h0, PRG_PROG_LO};
  wire [RUN_ADDR_W-1:0] font_off = fa - RUN_FONT_LO + {3'h0, PRG_FONT_LO};
  wire [RUN_ADDR_W-1:0] vec_off  = fa - RUN_VEC_LO + {3'h0, PRG_VEC_LO};
  wire [ADDR_W-1:0] run_idx = run_prog ? prog_off[ADDR_W-1:0] :
                              run_font ? font_off[ADDR_W-1:0] :
                                         vec_off[ADDR_W-1:0];
  wire run_hit = run_prog || run_font || run_vec;
  wire [WORD_W-1:0] r_word = run_idx[ADDR_W-1:LANE_W];
  wire [LANE_W-1:0] r_lane = run_idx[LANE_W-1:0];
  wire [ROW_W-1:0]  r_row  = mem[r_word];
  wire [7:0]        r_byte = r_row[8 * r_lane +: 8];

  // Erased state is all ones; whole rows cleared by a walk after reset
  always_ff @(posedge CLK_I)
  begin
    if (!mem_init)
      mem[init_idx] <= {FILL_LANES{ERASED}};
    else if (do_write)
      mem[s_word][8 * s_lane +: 8] <= s_byte & s_data;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      mem_init <= 1'b0;
      init_idx <= '0;
    end
    else if (!mem_init)
    begin
      init_idx <= init_idx + 1'b1;
      if (&init_idx)
        mem_init <= 1'b1;
    end
  end

  // Drive only with chip select and output enable both low; no signature area
  wire       next_oe         = selected && !s_oe_n && s_pgm_n;
  wire [7:0] next_pin_data   = readable ? s_byte : UNMAPPED;
  wire       next_fetch_vld  = FETCH_REQ_I && !prog_mode && mem_init;
  wire [7:0] next_fetch_data = run_hit ? r_byte : UNMAPPED;

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      DATA_LINES_OE_O <= 1'b0;
    else
      DATA_LINES_OE_O <= next_oe;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      DATA_LINES_O <= '0;
    else
      DATA_LINES_O <= next_pin_data;
  end

  // Run fetch is answered one cycle later; blocked in programming mode
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      FETCH_VALID_O <= 1'b0;
    else
      FETCH_VALID_O <= next_fetch_vld;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      FETCH_DATA_O <= '0;
    else
      FETCH_DATA_O <= next_fetch_data;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      PROGRAMMING_MODE_O <= 1'b0;
    else
      PROGRAMMING_MODE_O <= prog_mode;
  end
endmodule : otp_port
`default_nettype wire

// ---- otp_pkg.sv ----
// Constants for the one-time-programmable memory access port.
// Assumes a single 20 MHz clock and synchronous active-low reset.
package otp_pkg;
  localparam int unsigned ADDR_W     = 17;
  localparam int unsigned RUN_ADDR_W = 20;
  localparam int unsigned MEM_BYTES  = 131072;
  // Run-mode windows
  localparam logic [19:0] RUN_PROG_LO = 20'h04000;
  localparam logic [19:0] RUN_PROG_HI = 20'h13eff;
  localparam logic [19:0] RUN_FONT_LO = 20'h20000;
  localparam logic [19:0] RUN_FONT_HI = 20'h2a7ff;
  localparam logic [19:0] RUN_VEC_LO  = 20'hfff00;
  localparam logic [19:0] RUN_VEC_HI  = 20'hfffff;
  // Programming-mode windows
  localparam logic [16:0] PRG_PROG_LO = 17'h10000;
  localparam logic [16:0] PRG_PROG_HI = 17'h1feff;
  localparam logic [16:0] PRG_FONT_LO = 17'h05800;
  localparam logic [16:0] PRG_FONT_WR = 17'h0a000;
  localparam logic [16:0] PRG_FONT_HI = 17'h0ffff;
  localparam logic [16:0] PRG_VEC_LO  = 17'h1ff00;
  localparam logic [16:0] PRG_VEC_HI  = 17'h1ffff;
  localparam logic [7:0]  ERASED      = 8'hff;
  localparam logic [7:0]  UNMAPPED    = 8'hff;
  typedef enum logic [1:0] {
    OTP_IDLE   = 2'b00,
    OTP_BURN   = 2'b01,
    OTP_RELAX  = 2'b10
  } otp_strobe_t;
endpackage : otp_pkg

// ---- otp_port_properties.sv ----
// Pin-level checker for the OTP access port.
// Bound into otp_port; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module otp_port_properties (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic TEST_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic PROGRAM_STROBE_N_I,
  input wire logic FETCH_REQ_I,
  input wire logic FETCH_VALID_O,
  input wire logic DATA_LINES_OE_O,
  input wire logic PROGRAMMING_MODE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  AST_MODE_SYNC: assert property ($rose(PROGRAMMING_MODE_O) |-> $past(TEST_I, 3))
    else $error("mode rose early");
  AST_RUN_QUIET: assert property (DATA_LINES_OE_O |-> PROGRAMMING_MODE_O)
    else $error("drive in run mode");
  AST_OE_CAUSE: assert property (DATA_LINES_OE_O |-> !$past(OUTPUT_ENABLE_N_I, 3))
    else $error("drive without oe");
  AST_CS_CAUSE: assert property (DATA_LINES_OE_O |-> !$past(CHIP_SELECT_N_I, 3))
    else $error("drive without cs");
  AST_OE_DROP: assert property ($rose(OUTPUT_ENABLE_N_I) |-> ##[1:4] !DATA_LINES_OE_O)
    else $error("drive held");
  AST_STROBE_QUIET: assert property (DATA_LINES_OE_O |-> $past(PROGRAM_STROBE_N_I, 3))
    else $error("drive in strobe");
  AST_FETCH_CAUSE: assert property (FETCH_VALID_O |-> $past(FETCH_REQ_I))
    else $error("stray valid");
  AST_FETCH_RUN: assert property (FETCH_VALID_O |-> !PROGRAMMING_MODE_O)
    else $error("fetch in prog mode");
endmodule : otp_port_properties
bind otp_port otp_port_properties u_chk (.*);
`default_nettype wire

// ---- otp_prog_model.sv ----
// Behavioural parallel programmer for the OTP port pins.
// Bench resolves the data wire from both drive enables.
`timescale 1ns/1ps
`default_nettype none
module otp_prog_model #(parameter int PULSE = 2000) (
  input  wire logic        clk,
  input  wire logic [7:0]  d,
  output logic      [16:0] a,
  output logic      [7:0]  wd,
  output logic             pen,
  output logic             cs_n,
  output logic             oe_n,
  output logic             pgm_n
);
  initial {a, wd, pen, cs_n, oe_n, pgm_n} = {17'h0, 8'hff, 4'b0111};
  // Socket straps stay in the programming setting throughout
  logic       strap_high = 1'b1;
  logic [3:0] straps_low = 4'h0;
  logic       reset_pin  = 1'b0;
  logic       crystal_in = 1'b0;
  wire        setup_ok   = strap_high && !(|straps_low) && !reset_pin;
  always #62.5 crystal_in = ~crystal_in;
  task automatic look(input logic [16:0] adr, output logic [7:0] got);
    got = 8'h00;
    if (!setup_ok)
      return;
    @(negedge clk);
    {a, pen, cs_n, oe_n} = {adr, 3'b000};
    repeat (4) @(negedge clk);
    got = d;
    {cs_n, oe_n} = 2'b11;
    repeat (4) @(negedge clk);
  endtask : look
  // No signature probe; device type is fixed here
  task automatic burn(input logic [16:0] adr, input logic [7:0] v, output logic [7:0] got);
    got = 8'h00;
    if (!setup_ok)
      return;
    for (int n = 0; n < 25; n++)
    begin
      @(negedge clk);
      {a, wd, pen, cs_n} = {adr, v, 2'b10};
      repeat (4) @(negedge clk);
      pgm_n = 1'b0;
      repeat (PULSE) @(negedge clk);
      pgm_n = 1'b1;
      repeat (4) @(negedge clk);
      look(adr, got);
      if (got === v) break;
    end
  endtask : burn
endmodule : otp_prog_model
`default_nettype wire

// ---- otp_prom_programming_port_bench.sv ----
// Bench for the OTP port: programs bytes, then fetches in run mode.
// Waits out the erase fill after reset.
`timescale 1ns/1ps
`default_nettype none
module otp_prom_programming_port_bench;
  logic        clk = 0, rstn = 0, test = 0, req = 0, cs_n, oe_n, pgm_n, pen, doe, vld, mode;
  logic [16:0] a;
  logic [7:0]  wd, dout, fdat, got;
  logic [19:0] fa = 20'h0;
  int          n_mismatch = 0, tests_run = 0;
  localparam int FILL_LANES = 8;
  logic [16:0] pa [4] = '{17'h10000, 17'h0a000, 17'h1ff00, 17'h05800};
  logic [19:0] ra [4] = '{20'h04000, 20'h24800, 20'hfff00, 20'h20000};
  logic [7:0]  pv [4] = '{8'h3c, 8'ha5, 8'h5a, 8'h00};
  logic [7:0]  pe [4] = '{8'h3c, 8'ha5, 8'h5a, 8'hff};
  // Released wire shows inverse, not a stale value
  wire  [7:0]  dw = doe ? dout : (pen ? wd : ~wd);
  always #25 clk = ~clk;
  otp_port #(.FILL_LANES(FILL_LANES)) u_otp_port (.CLK_I(clk), .RSTN_I(rstn), .TEST_I(test),
    .UPPER_ADDRESS_BIT_I(a[16]),
    .ADDRESS_HIGH_BYTE_I(a[15:8]), .ADDRESS_LOW_BYTE_I(a[7:0]), .DATA_LINES_I(dw),
    .DATA_LINES_O(dout), .DATA_LINES_OE_O(doe), .CHIP_SELECT_N_I(cs_n),
    .OUTPUT_ENABLE_N_I(oe_n), .PROGRAM_STROBE_N_I(pgm_n), .FETCH_ADDR_I(fa),
    .FETCH_REQ_I(req), .FETCH_DATA_O(fdat), .FETCH_VALID_O(vld), .PROGRAMMING_MODE_O(mode));
  otp_prog_model u_otp_prog_model (.clk(clk), .d(dw), .a(a), .wd(wd), .pen(pen),
    .cs_n(cs_n), .oe_n(oe_n), .pgm_n(pgm_n));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic t_prog();
    test = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h0, mode}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      u_otp_prog_model.burn(pa[i], pv[i], got);
      chk(got, pe[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      u_otp_prog_model.look(pa[i], got);
      chk(got, pe[i]);
    end
    $display("t_prog done");
  endtask : t_prog
  task automatic t_run();
    test = 1'b0;
    repeat (4) @(negedge clk);
    chk({7'h0, mode}, 8'h00);
    req = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      fa = ra[i];
      @(negedge clk);
      chk({vld, 7'h0}, 8'h80);
      chk(fdat, pe[i]);
    end
    req = 1'b0;
    $display("t_run done");
  endtask : t_run
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    repeat (otp_pkg::MEM_BYTES / FILL_LANES + 8) @(negedge clk);
    t_prog();
    t_run();
    results();
  end
endmodule : otp_prom_programming_port_bench
`default_nettype wire
